// ---- include/ccs_pkg.sv ----
`default_nettype none

package ccs_pkg;

    // Command codes taken from the first byte after the address.
    localparam logic [7:0] CCS_CMD_CONFIG_WRITE = 8'hD2;
    localparam logic [7:0] CCS_CMD_CHANNEL_SEL  = 8'hC3;

    // Configuration byte layout: the high nibble must be the inverse of the low one.
    localparam int CCS_CFG_LO_MSB = 3;
    localparam int CCS_CFG_HI_LSB = 4;
    localparam logic [3:0] CCS_CFG_READ_HI = 4'h0;

    localparam int CCS_CHANNELS = 8;
    localparam logic [2:0] CCS_CHAN_RESET = 3'h0;

    // Codes written to select a channel, and the codes read back, which differ from them except for channel seven (87h).
    localparam logic [7:0] CCS_CHAN_WR_CODE [CCS_CHANNELS] = '{
        8'hF0, 8'hE1, 8'hD2, 8'hC3, 8'hB4, 8'hA5, 8'h96, 8'h87};
    localparam logic [7:0] CCS_CHAN_RD_CODE [CCS_CHANNELS] = '{
        8'hB8, 8'hB1, 8'hAA, 8'hA3, 8'h9C, 8'h95, 8'h8E, 8'h87};

    localparam logic [7:0] CCS_READ_OTHER = 8'h00;

    typedef struct packed {
        logic bus_speed_select;
        logic strong_pullup_enable;
        logic presence_mask_enable;
        logic active_pullup_enable;
    } ccs_cfg_type;

    localparam ccs_cfg_type CCS_CFG_RESET = '{default: 1'b0};

    // Read pointer positions; commands steer only the last two, and a reset returns the pointer to the first.
    typedef enum logic [1:0] {
        CCS_PTR_STATUS  = 2'b00,
        CCS_PTR_DATA    = 2'b01,
        CCS_PTR_CHANNEL = 2'b10,
        CCS_PTR_CONFIG  = 2'b11
    } ccs_ptr_type;

    typedef enum logic [1:0] {
        CCS_ST_IDLE = 2'b00,
        CCS_ST_CFG  = 2'b01,
        CCS_ST_CHAN = 2'b10,
        CCS_ST_SKIP = 2'b11
    } ccs_state_type;

endpackage : ccs_pkg

`default_nettype wire

// ---- logic/ccs_config_channel.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A config-write code followed by one config byte stores new bus settings that apply at once.
// - A config byte is stored only when its high nibble is the bitwise inverse of its low nibble.
// - Reading the config register gives zeros in the high nibble and the settings in the low nibble.
// - The config register changes on the rising clock edge of the acknowledge after the config byte.
// - If the line is busy when either command code arrives, neither the code nor its parameter is acknowledged.
// - After a config write the read pointer sits on the config register.
// - A config write updates speed, strong pullup, presence masking and active pullup, and starts no bus activity.
// - A channel-select code followed by one selection byte picks the bus channel for later bus commands.
// - Selection codes F0h down to 87h pick channels zero to seven, and channel zero is the default.
// - The channel register reads back B8h down to 87h for channels zero to seven.
// - A selection byte that matches no valid code is not acknowledged and leaves the channel unchanged.
// - The channel register changes on the rising clock edge of the acknowledge after a valid selection byte.
// - After a channel select the read pointer sits on the channel register.
// - A successful config write clears the reset-occurred flag.
// - A device reset selects channel zero and clears all four settings.
module ccs_config_channel
    import ccs_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Byte stream from the serial front end
    input  wire logic        byte_valid,
    input  wire logic        byte_first,
    input  wire logic [7:0]  byte_data,
    input  wire logic        ack_edge,
    // Device state
    input  wire logic        line_busy_flag,
    input  wire logic        device_reset,
    // Acknowledge decision
    output logic             ack_claim_reg,
    output logic             ack_reg,
    // Settings and selection
    output ccs_cfg_type      cfg_reg,
    output logic [2:0]       channel_reg,
    output logic             reset_occurred_reg,
    // Read-back
    output ccs_ptr_type      read_ptr_reg,
    output logic [7:0]       read_data_reg
);

    ccs_state_type state_reg;
    logic          commit_cfg_reg;
    logic          commit_chan_reg;
    logic          move_cfg_ptr_reg;
    logic [7:0]    param_reg;
    logic [2:0]    chan_pick_reg;
    logic          cfg_ok;
    logic          chan_ok;
    logic [2:0]    chan_idx;
    logic [CCS_CHANNELS-1:0] chan_hit;

    assign cfg_ok = (byte_data[7:CCS_CFG_HI_LSB] == ~byte_data[CCS_CFG_LO_MSB:0]);

    genvar g;
    generate
        for (g = 0; g < CCS_CHANNELS; g++) begin : g_match
            assign chan_hit[g] = (byte_data == CCS_CHAN_WR_CODE[g]);
        end
    endgenerate

    assign chan_ok = |chan_hit;

    always_comb begin
        chan_idx = CCS_CHAN_RESET;
        for (int i = 0; i < CCS_CHANNELS; i++) begin
            if (chan_hit[i]) begin
                chan_idx = 3'(i);
            end
        end
    end

    // Command decode. A first byte always restarts decoding, so a repeated start
    // abandons any half-received command.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg       <= CCS_ST_IDLE;
            ack_claim_reg   <= 1'b0;
            ack_reg         <= 1'b0;
            commit_cfg_reg  <= 1'b0;
            commit_chan_reg <= 1'b0;
            move_cfg_ptr_reg <= 1'b0;
            param_reg       <= 8'h00;
            chan_pick_reg   <= CCS_CHAN_RESET;
        end else if (clk_en) begin
            if (device_reset) begin
                state_reg       <= CCS_ST_IDLE;
                ack_claim_reg   <= 1'b0;
                ack_reg         <= 1'b0;
                commit_cfg_reg  <= 1'b0;
                commit_chan_reg <= 1'b0;
                move_cfg_ptr_reg <= 1'b0;
            end else if (byte_valid && byte_first) begin
                commit_cfg_reg  <= 1'b0;
                commit_chan_reg <= 1'b0;
                move_cfg_ptr_reg <= 1'b0;
                if (byte_data == CCS_CMD_CONFIG_WRITE || byte_data == CCS_CMD_CHANNEL_SEL) begin
                    ack_claim_reg <= 1'b1;
                    ack_reg       <= !line_busy_flag;
                    if (line_busy_flag) begin
                        state_reg <= CCS_ST_SKIP;
                    end else if (byte_data == CCS_CMD_CONFIG_WRITE) begin
                        state_reg <= CCS_ST_CFG;
                    end else begin
                        state_reg <= CCS_ST_CHAN;
                    end
                end else begin
                    ack_claim_reg <= 1'b0;
                    ack_reg       <= 1'b0;
                    state_reg     <= CCS_ST_IDLE;
                end
            end else if (byte_valid) begin
                param_reg <= byte_data;
                state_reg <= CCS_ST_IDLE;
                unique case (state_reg)
                    CCS_ST_IDLE: begin
                        ack_claim_reg <= 1'b0;
                        ack_reg       <= 1'b0;
                    end
                    CCS_ST_CFG: begin
                        ack_claim_reg    <= 1'b1;
                        ack_reg          <= 1'b1;
                        commit_cfg_reg   <= cfg_ok;
                        move_cfg_ptr_reg <= 1'b1;
                    end
                    CCS_ST_CHAN: begin
                        ack_claim_reg   <= 1'b1;
                        ack_reg         <= chan_ok;
                        commit_chan_reg <= chan_ok;
                        chan_pick_reg   <= chan_idx;
                    end
                    CCS_ST_SKIP: begin
                        ack_claim_reg <= 1'b1;
                        ack_reg       <= 1'b0;
                    end
                endcase
            end else if (ack_edge) begin
                commit_cfg_reg   <= 1'b0;
                commit_chan_reg  <= 1'b0;
                move_cfg_ptr_reg <= 1'b0;
            end
        end
    end

    // Settings register. Storing it starts nothing on the bus line.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= CCS_CFG_RESET;
        end else if (clk_en) begin
            if (device_reset) begin
                cfg_reg <= CCS_CFG_RESET;
            end else if (ack_edge && commit_cfg_reg) begin
                cfg_reg <= ccs_cfg_type'(param_reg[CCS_CFG_LO_MSB:0]);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_reg <= CCS_CHAN_RESET;
        end else if (clk_en) begin
            if (device_reset) begin
                channel_reg <= CCS_CHAN_RESET;
            end else if (ack_edge && commit_chan_reg) begin
                // The decoded index is stored, not bits of the code, so the table may change freely.
                channel_reg <= chan_pick_reg;
            end
        end
    end

    // The reset event wins over a clear arriving in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_occurred_reg <= 1'b1;
        end else if (clk_en) begin
            if (device_reset) begin
                reset_occurred_reg <= 1'b1;
            end else if (ack_edge && commit_cfg_reg) begin
                reset_occurred_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_ptr_reg <= CCS_PTR_STATUS;
        end else if (clk_en) begin
            if (device_reset) begin
                read_ptr_reg <= CCS_PTR_STATUS;
            end else if (ack_edge && move_cfg_ptr_reg) begin
                read_ptr_reg <= CCS_PTR_CONFIG;
            end else if (ack_edge && commit_chan_reg) begin
                read_ptr_reg <= CCS_PTR_CHANNEL;
            end
        end
    end

    // Read data trails the registers by one cycle, which the front end easily absorbs
    // since a read byte is only shifted out many clocks after the pointer moves.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data_reg <= CCS_READ_OTHER;
        end else if (clk_en) begin
            unique case (read_ptr_reg)
                CCS_PTR_CONFIG:  read_data_reg <= {CCS_CFG_READ_HI, cfg_reg};
                CCS_PTR_CHANNEL: read_data_reg <= CCS_CHAN_RD_CODE[channel_reg];
                default:         read_data_reg <= CCS_READ_OTHER;
            endcase
        end
    end

    a_busy_no_ack: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !device_reset && byte_valid && byte_first && line_busy_flag
        && (byte_data == CCS_CMD_CONFIG_WRITE || byte_data == CCS_CMD_CHANNEL_SEL)
        |=> ack_claim_reg && !ack_reg && state_reg == CCS_ST_SKIP)
        else $error("busy command was acknowledged");

    a_bad_cfg_kept: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ack_edge && !commit_cfg_reg && !device_reset
        |=> $stable(cfg_reg) && $stable(reset_occurred_reg))
        else $error("settings changed without a valid config byte");

    a_cfg_store: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ack_edge && commit_cfg_reg && !device_reset
        |=> cfg_reg == ccs_cfg_type'($past(param_reg[CCS_CFG_LO_MSB:0])) && !reset_occurred_reg)
        else $error("config not stored on acknowledge edge");

    a_cfg_check: assert property (@(posedge clk) disable iff (!reset_n)
        commit_cfg_reg |-> param_reg[7:CCS_CFG_HI_LSB] == ~param_reg[CCS_CFG_LO_MSB:0])
        else $error("config byte pending without complement match");

    a_bad_sel_nack: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !device_reset && byte_valid && !byte_first && state_reg == CCS_ST_CHAN && !chan_ok
        |=> !ack_reg && !commit_chan_reg)
        else $error("invalid selection code acknowledged");

    a_chan_ptr: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ack_edge && commit_chan_reg && !move_cfg_ptr_reg && !device_reset
        |=> read_ptr_reg == CCS_PTR_CHANNEL ##1 !clk_en || read_data_reg == CCS_CHAN_RD_CODE[channel_reg])
        else $error("channel pointer or read-back wrong");

    a_cfg_readback: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && $past(clk_en) && read_ptr_reg == CCS_PTR_CONFIG && $past(read_ptr_reg) == CCS_PTR_CONFIG
        |-> read_data_reg == {CCS_CFG_READ_HI, $past(cfg_reg)})
        else $error("config read-back high nibble not zero");

    a_reset_default: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && device_reset
        |=> channel_reg == CCS_CHAN_RESET && cfg_reg == CCS_CFG_RESET && reset_occurred_reg)
        else $error("device reset did not restore defaults");

endmodule : ccs_config_channel

`default_nettype wire

// ---- bench/ccs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host side of the byte stream: a command byte, one parameter byte, then the acknowledge edge.
module ccs_host_model (
    // Clock
    input  wire logic       clk,
    // Byte stream towards the block
    output logic            byte_valid,
    output logic            byte_first,
    output logic [7:0]      byte_data,
    output logic            ack_edge
);
    initial begin
        byte_valid = 1'b0;
        byte_first = 1'b0;
        byte_data  = 8'hA5;
        ack_edge   = 1'b0;
    end

    // Once a byte is gone its data turns to the inverse, so a stale value cannot pass for a live one.
    task automatic send_byte(input logic first, input logic [7:0] data);
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_first <= first;
        byte_data  <= data;
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_first <= 1'b0;
        byte_data  <= ~data;
    endtask : send_byte

    task automatic ack_pulse();
        @(posedge clk);
        ack_edge <= 1'b1;
        @(posedge clk);
        ack_edge <= 1'b0;
    endtask : ack_pulse
endmodule : ccs_host_model

`default_nettype wire

// ---- bench/ccs_config_channel_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module ccs_config_channel_bench;
    import ccs_pkg::*;

    localparam logic [7:0] WR_CODE [8] = '{8'hF0, 8'hE1, 8'hD2, 8'hC3, 8'hB4, 8'hA5, 8'h96, 8'h87};
    localparam logic [7:0] RD_CODE [8] = '{8'hB8, 8'hB1, 8'hAA, 8'hA3, 8'h9C, 8'h95, 8'h8E, 8'h87};

    logic        clk = 1'b0;
    logic        reset_n, clk_en, line_busy_flag, device_reset;
    logic        byte_valid, byte_first, ack_edge;
    logic [7:0]  byte_data, read_data_reg;
    logic        ack_claim_reg, ack_reg, reset_occurred_reg;
    ccs_cfg_type cfg_reg;
    logic [2:0]  channel_reg, exp_chan;
    ccs_ptr_type read_ptr_reg;
    logic [3:0]  exp_cfg;
    logic [1:0]  exp_ptr;
    logic        exp_rst;
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;

    ccs_host_model u_ccs_host_model (.clk(clk), .byte_valid(byte_valid), .byte_first(byte_first),
        .byte_data(byte_data), .ack_edge(ack_edge));

    ccs_config_channel u_ccs_config_channel (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .byte_valid(byte_valid), .byte_first(byte_first), .byte_data(byte_data), .ack_edge(ack_edge),
        .line_busy_flag(line_busy_flag), .device_reset(device_reset), .ack_claim_reg(ack_claim_reg),
        .ack_reg(ack_reg), .cfg_reg(cfg_reg), .channel_reg(channel_reg),
        .reset_occurred_reg(reset_occurred_reg), .read_ptr_reg(read_ptr_reg), .read_data_reg(read_data_reg));

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic check_state(input string name);
        chk("cfg_reg", {4'h0, exp_cfg}, {4'h0, cfg_reg});
        chk("channel_reg", {5'h00, exp_chan}, {5'h00, channel_reg});
        chk("reset_occurred_reg", {7'h00, exp_rst}, {7'h00, reset_occurred_reg});
        chk("read_ptr_reg", {6'h00, exp_ptr}, {6'h00, read_ptr_reg});
        chk("read_data_reg", (exp_ptr == 2'b11) ? {4'h0, exp_cfg} : (exp_ptr == 2'b10) ? RD_CODE[exp_chan] : 8'h00,
            read_data_reg);
        $display("test %s done", name);
    endtask : check_state

    // State must not move before the acknowledge edge; it is judged two edges after it.
    task automatic cmd(input logic [7:0] code, input logic [7:0] par, input logic busy, input logic ca,
                       input logic pa);
        @(posedge clk);
        line_busy_flag <= busy;
        u_ccs_host_model.send_byte(1'b1, code);
        @(posedge clk);
        #1;
        chk("code ack", 8'h02 | ca, {6'h00, ack_claim_reg, ack_reg});
        u_ccs_host_model.send_byte(1'b0, par);
        @(posedge clk);
        #1;
        chk("param ack", 8'h02 | pa, {6'h00, ack_claim_reg, ack_reg});
        chk("early cfg", {4'h0, exp_cfg}, {4'h0, cfg_reg});
        chk("early channel", {5'h00, exp_chan}, {5'h00, channel_reg});
        u_ccs_host_model.ack_pulse();
        repeat (2) @(posedge clk);
        line_busy_flag <= 1'b0;
        #1;
    endtask : cmd

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        line_busy_flag = 1'b0;
        device_reset = 1'b0;
        {exp_cfg, exp_chan, exp_rst, exp_ptr} = {4'h0, 3'h0, 1'b1, 2'b00};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check_state("reset");
        cmd(8'hD2, 8'h3C, 1'b0, 1'b1, 1'b1);
        {exp_cfg, exp_rst, exp_ptr} = {4'hC, 1'b0, 2'b11};
        check_state("config write");
        cmd(8'hD2, 8'h5A, 1'b1, 1'b0, 1'b0);
        cmd(8'hC3, 8'hB4, 1'b1, 1'b0, 1'b0);
        check_state("busy");
        for (int i = 7; i >= 0; i--) begin
            cmd(8'hC3, WR_CODE[i], 1'b0, 1'b1, 1'b1);
            {exp_chan, exp_ptr} = {i[2:0], 2'b10};
            check_state("channel select");
        end
        cmd(8'hC3, 8'h55, 1'b0, 1'b1, 1'b0);
        check_state("bad selection");
        cmd(8'hC3, 8'h96, 1'b0, 1'b1, 1'b1);
        exp_chan = 3'h6;
        @(posedge clk);
        device_reset <= 1'b1;
        @(posedge clk);
        device_reset <= 1'b0;
        @(posedge clk);
        #1;
        {exp_cfg, exp_chan, exp_rst, exp_ptr} = {4'h0, 3'h0, 1'b1, 2'b00};
        check_state("device reset");
        cmd(8'hD2, 8'h3D, 1'b0, 1'b1, 1'b1);
        exp_ptr = 2'b11;
        check_state("bad config");
        cmd(8'hD2, 8'h87, 1'b0, 1'b1, 1'b1);
        {exp_cfg, exp_rst} = {4'h7, 1'b0};
        check_state("config low bits");
        // A reset request that arrives while the enable is low must leave every setting alone.
        @(posedge clk);
        clk_en <= 1'b0;
        device_reset <= 1'b1;
        @(posedge clk);
        clk_en <= 1'b1;
        device_reset <= 1'b0;
        @(posedge clk);
        #1;
        check_state("frozen");
        test_done();
    end
endmodule : ccs_config_channel_bench

`default_nettype wire
